// file: hw/sgc_general_control.v
// What this block does
// - Main control bit 15 enables frequency ramping when 1, resets to 0.
// - Main control bit 14 enables output phase synchronization, reset 0.
// - With main control bit 9 set and register 7 bit 14 clear, outputs stay muted during calibration.
// - Every write putting 1 in main control bit 3 and 0 in bits 1 and 0 starts a calibration.
// - Main control bit 2 routes readback (0) or lock detect (1) to the pin.
// - While main control bit 1 is 1, all other registers and the calibration sequencer hold defaults.
// - Main control bit 0 powers down while it is 1: pin low, outputs disabled, calibration stopped; registers stay writable.
// - Register 1 bits 2:0 divide the calibration clock by 1, 2, 4 or 8.
// - Register 7 bit 14 with the mute bit decides output disable in cal.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
`include "sgc_regs.vh"

module sgc_general_control #(
    parameter CAL_TICKS = `SGC_CAL_TICKS
) (
    input wire aclk,
    input wire aresetn,
    input wire [8:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [8:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire lock_detect,
    input wire readback_data,
    output reg multiplexed_output_pin,
    output wire ramp_enable,
    output wire output_phase_sync_enable,
    output wire [1:0] cal_high_compare_rate_range,
    output wire [1:0] cal_low_compare_rate_range,
    output wire device_power_down,
    output reg calibration_busy,
    output reg outputs_disabled,
    output wire [15:0] ramp_threshold_value,
    output wire [15:0] ramp_threshold_value_low,
    output wire [31:0] ramp_upper_limit,
    output wire [31:0] ramp_lower_limit
);

reg [15:0] main_control;
reg [15:0] calibration_clock_setup;
reg [15:0] output_force_control;
reg [15:0] ramp_threshold_high;
reg [15:0] ramp_threshold_low;
reg [15:0] ramp_upper_limit_high;
reg [15:0] ramp_upper_limit_low;
reg [15:0] ramp_lower_limit_high;
reg [15:0] ramp_lower_limit_low;

reg aw_held;
reg w_held;
reg [6:0] aw_index;
reg [31:0] w_data;
reg [3:0] w_strb;
reg [7:0] div_count;
reg [7:0] cal_count;
reg cal_start;

wire soft_reset = main_control[`SGC_BIT_SOFT_RESET];
wire write_go = aw_held && w_held && !s_axi_bvalid;
wire [15:0] wmask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
wire [15:0] wval = w_data[15:0];
wire [6:0] ar_index = s_axi_araddr[8:2];

assign s_axi_awready = !aw_held && !s_axi_bvalid;
assign s_axi_wready = !w_held && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;

assign ramp_enable = main_control[`SGC_BIT_RAMP_EN];
assign output_phase_sync_enable = main_control[`SGC_BIT_PHASE_SYNC];
assign cal_high_compare_rate_range =
    main_control[`SGC_HPFD_MSB:`SGC_HPFD_LSB];
assign cal_low_compare_rate_range =
    main_control[`SGC_LPFD_MSB:`SGC_LPFD_LSB];
assign device_power_down = main_control[`SGC_BIT_POWER_DOWN];
assign ramp_threshold_value = ramp_threshold_high;
assign ramp_threshold_value_low = ramp_threshold_low;
assign ramp_upper_limit = {ramp_upper_limit_high, ramp_upper_limit_low};
assign ramp_lower_limit = {ramp_lower_limit_high, ramp_lower_limit_low};

function [15:0] merge;
    input [15:0] old_value;
    input [15:0] new_value;
    input [15:0] mask;
    begin
        merge = (old_value & ~mask) | (new_value & mask);
    end
endfunction

// write address and data are taken in either order
always @(posedge aclk) begin
    if (!aresetn) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        aw_index <= 7'h00;
        w_data <= 32'h00000000;
        w_strb <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= 2'b00;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_index <= s_axi_awaddr[8:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        if (write_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'b00;
            if (aw_index != `SGC_IDX_MAIN_CONTROL &&
                aw_index != `SGC_IDX_CAL_CLOCK_SETUP &&
                aw_index != `SGC_IDX_OUTPUT_FORCE &&
                aw_index != `SGC_IDX_RAMP_THR_HIGH &&
                aw_index != `SGC_IDX_RAMP_THR_LOW &&
                aw_index != `SGC_IDX_RAMP_UPPER_HIGH &&
                aw_index != `SGC_IDX_RAMP_UPPER_LOW &&
                aw_index != `SGC_IDX_RAMP_LOWER_HIGH &&
                aw_index != `SGC_IDX_RAMP_LOWER_LOW) begin
                s_axi_bresp <= 2'b10;
            end
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// register file; soft reset holds all but main_control at defaults
always @(posedge aclk) begin
    cal_start <= 1'b0;
    if (!aresetn) begin
        main_control <= `SGC_RST_MAIN_CONTROL;
        calibration_clock_setup <= `SGC_RST_CAL_CLOCK_SETUP;
        output_force_control <= `SGC_RST_OUTPUT_FORCE;
        ramp_threshold_high <= `SGC_RST_RAMP;
        ramp_threshold_low <= `SGC_RST_RAMP;
        ramp_upper_limit_high <= `SGC_RST_RAMP;
        ramp_upper_limit_low <= `SGC_RST_RAMP;
        ramp_lower_limit_high <= `SGC_RST_RAMP;
        ramp_lower_limit_low <= `SGC_RST_RAMP;
    end else begin
        if (soft_reset) begin
            // main_control stays writable, or the reset could never end
            main_control <= `SGC_RST_MAIN_CONTROL |
                (16'h0001 << `SGC_BIT_SOFT_RESET);
            calibration_clock_setup <= `SGC_RST_CAL_CLOCK_SETUP;
            output_force_control <= `SGC_RST_OUTPUT_FORCE;
            ramp_threshold_high <= `SGC_RST_RAMP;
            ramp_threshold_low <= `SGC_RST_RAMP;
            ramp_upper_limit_high <= `SGC_RST_RAMP;
            ramp_upper_limit_low <= `SGC_RST_RAMP;
            ramp_lower_limit_high <= `SGC_RST_RAMP;
            ramp_lower_limit_low <= `SGC_RST_RAMP;
        end
        if (write_go) begin
            if (aw_index == `SGC_IDX_MAIN_CONTROL) begin
                main_control <= merge(main_control, wval, wmask);
                if (w_strb[0] && wval[`SGC_BIT_CAL_TRIGGER] &&
                    !wval[`SGC_BIT_SOFT_RESET]) begin
                    cal_start <= 1'b1;
                end
            end else if (soft_reset) begin
                // other registers ignore writes while held in reset
            end else if (aw_index == `SGC_IDX_CAL_CLOCK_SETUP) begin
                calibration_clock_setup <=
                    merge(calibration_clock_setup, wval, wmask);
            end else if (aw_index == `SGC_IDX_OUTPUT_FORCE) begin
                output_force_control <=
                    merge(output_force_control, wval, wmask);
            end else if (aw_index == `SGC_IDX_RAMP_THR_HIGH) begin
                ramp_threshold_high <= merge(ramp_threshold_high, wval, wmask);
            end else if (aw_index == `SGC_IDX_RAMP_THR_LOW) begin
                ramp_threshold_low <= merge(ramp_threshold_low, wval, wmask);
            end else if (aw_index == `SGC_IDX_RAMP_UPPER_HIGH) begin
                ramp_upper_limit_high <=
                    merge(ramp_upper_limit_high, wval, wmask);
            end else if (aw_index == `SGC_IDX_RAMP_UPPER_LOW) begin
                ramp_upper_limit_low <=
                    merge(ramp_upper_limit_low, wval, wmask);
            end else if (aw_index == `SGC_IDX_RAMP_LOWER_HIGH) begin
                ramp_lower_limit_high <=
                    merge(ramp_lower_limit_high, wval, wmask);
            end else if (aw_index == `SGC_IDX_RAMP_LOWER_LOW) begin
                ramp_lower_limit_low <=
                    merge(ramp_lower_limit_low, wval, wmask);
            end
        end
    end
end

// calibration clock divider: tick every 1, 2, 4 or 8 cycles
reg [7:0] div_limit;
always @* begin
    case (calibration_clock_setup[`SGC_DIV_MSB:`SGC_DIV_LSB])
        3'h0: div_limit = 8'h00;
        3'h1: div_limit = 8'h01;
        3'h2: div_limit = 8'h03;
        default: div_limit = 8'h07;
    endcase
end
wire cal_tick = (div_count >= div_limit);

// last tick index, cut to the counter width on purpose
localparam [31:0] CAL_TICKS_W = CAL_TICKS;
localparam [7:0] CAL_LAST = CAL_TICKS_W[7:0] - 8'h01;

// calibration sequencer; power-down and soft reset abort it
always @(posedge aclk) begin
    if (!aresetn || soft_reset || device_power_down) begin
        div_count <= 8'h00;
        cal_count <= 8'h00;
        calibration_busy <= 1'b0;
    end else if (cal_start) begin
        div_count <= 8'h00;
        cal_count <= 8'h00;
        calibration_busy <= 1'b1;
    end else if (calibration_busy) begin
        if (cal_tick) begin
            div_count <= 8'h00;
            if (cal_count == CAL_LAST) begin
                calibration_busy <= 1'b0;
            end else begin
                cal_count <= cal_count + 8'h01;
            end
        end else begin
            div_count <= div_count + 8'h01;
        end
    end
end

// outputs and the muxed pin
always @(posedge aclk) begin
    if (!aresetn) begin
        outputs_disabled <= 1'b0;
        multiplexed_output_pin <= 1'b0;
    end else begin
        // forced-output only matters when mute is on during calibration
        outputs_disabled <= device_power_down || (calibration_busy &&
            main_control[`SGC_BIT_CAL_MUTE] &&
            !output_force_control[`SGC_BIT_FORCE_OUT]);
        if (device_power_down) begin
            multiplexed_output_pin <= 1'b0;
        end else if (main_control[`SGC_BIT_MUX_SEL]) begin
            multiplexed_output_pin <= lock_detect;
        end else begin
            multiplexed_output_pin <= readback_data;
        end
    end
end

// read channel
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        if (ar_index == `SGC_IDX_MAIN_CONTROL) begin
            s_axi_rdata <= {16'h0000, main_control};
        end else if (ar_index == `SGC_IDX_CAL_CLOCK_SETUP) begin
            s_axi_rdata <= {16'h0000, calibration_clock_setup};
        end else if (ar_index == `SGC_IDX_OUTPUT_FORCE) begin
            s_axi_rdata <= {16'h0000, output_force_control};
        end else if (ar_index == `SGC_IDX_RAMP_THR_HIGH) begin
            s_axi_rdata <= {16'h0000, ramp_threshold_high};
        end else if (ar_index == `SGC_IDX_RAMP_THR_LOW) begin
            s_axi_rdata <= {16'h0000, ramp_threshold_low};
        end else if (ar_index == `SGC_IDX_RAMP_UPPER_HIGH) begin
            s_axi_rdata <= {16'h0000, ramp_upper_limit_high};
        end else if (ar_index == `SGC_IDX_RAMP_UPPER_LOW) begin
            s_axi_rdata <= {16'h0000, ramp_upper_limit_low};
        end else if (ar_index == `SGC_IDX_RAMP_LOWER_HIGH) begin
            s_axi_rdata <= {16'h0000, ramp_lower_limit_high};
        end else if (ar_index == `SGC_IDX_RAMP_LOWER_LOW) begin
            s_axi_rdata <= {16'h0000, ramp_lower_limit_low};
        end else if (ar_index == `SGC_IDX_STATUS) begin
            s_axi_rdata <= {29'h00000000, outputs_disabled,
                multiplexed_output_pin, calibration_busy};
        end else begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b10;
        end
    end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

endmodule // sgc_general_control

// file: hw/sgc_regs.vh
`ifndef SGC_REGS_VH
`define SGC_REGS_VH

// register indices; byte address is four times the index
`define SGC_IDX_MAIN_CONTROL 7'h00
`define SGC_IDX_CAL_CLOCK_SETUP 7'h01
`define SGC_IDX_OUTPUT_FORCE 7'h07
`define SGC_IDX_RAMP_THR_HIGH 7'h4f
`define SGC_IDX_RAMP_THR_LOW 7'h50
`define SGC_IDX_RAMP_UPPER_HIGH 7'h52
`define SGC_IDX_RAMP_UPPER_LOW 7'h53
`define SGC_IDX_RAMP_LOWER_HIGH 7'h55
`define SGC_IDX_RAMP_LOWER_LOW 7'h56
`define SGC_IDX_STATUS 7'h70

// main_control fields
`define SGC_BIT_RAMP_EN 15
`define SGC_BIT_PHASE_SYNC 14
`define SGC_BIT_CAL_MUTE 9
`define SGC_HPFD_MSB 8
`define SGC_HPFD_LSB 7
`define SGC_LPFD_MSB 6
`define SGC_LPFD_LSB 5
`define SGC_BIT_CAL_TRIGGER 3
`define SGC_BIT_MUX_SEL 2
`define SGC_BIT_SOFT_RESET 1
`define SGC_BIT_POWER_DOWN 0

// calibration_clock_setup and output_force_control fields
`define SGC_DIV_MSB 2
`define SGC_DIV_LSB 0
`define SGC_BIT_FORCE_OUT 14

// reset values
`define SGC_RST_MAIN_CONTROL 16'h0000
`define SGC_RST_CAL_CLOCK_SETUP 16'h0003
`define SGC_RST_OUTPUT_FORCE 16'h0000
`define SGC_RST_RAMP 16'h0000

// calibration length in divided calibration clock ticks
`define SGC_CAL_TICKS 8'h40

`endif

// file: bench/sgc_general_control_assertions.sv
`timescale 1ns/100ps
module sgc_gc_chk (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire multiplexed_output_pin,
    input wire device_power_down,
    input wire calibration_busy,
    input wire outputs_disabled
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response not two cycles after request");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready) else $error("read answer late");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data unstable");
    pd_pin_a: assert property ($past(device_power_down) |->
        !multiplexed_output_pin) else $error("pin driven in power down");
    pd_off_a: assert property ($past(device_power_down) |->
        outputs_disabled) else $error("outputs live in power down");
    mute_cause_a: assert property (outputs_disabled |->
        $past(device_power_down) || $past(calibration_busy))
        else $error("outputs disabled without cause");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property ($rose(calibration_busy));
    cover property ($rose(outputs_disabled) && !device_power_down);
endmodule // sgc_gc_chk

// file: bench/testbench.sv
`timescale 1ns/100ps
`include "sgc_regs.vh"
module testbench;
    localparam logic [6:0] MC = `SGC_IDX_MAIN_CONTROL;
    localparam logic [6:0] DIV = `SGC_IDX_CAL_CLOCK_SETUP;
    localparam logic [6:0] FRC = `SGC_IDX_OUTPUT_FORCE;
    localparam int TICKS = 4;
    logic aclk = 1'b0, aresetn = 1'b0, lock = 1'b0, rbk = 1'b0, seen;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [8:0] awaddr = 9'h000, araddr = 9'h000;
    logic [31:0] wdata = 32'h00000000, got;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] rsp;
    int errors = 0, checked = 0, cycles = 0, n, d;
    wire awready, wready, bvalid, arready, rvalid, pin, ramp, sync, pd, busy;
    wire od;
    wire [1:0] bresp, rresp, hi_rng, lo_rng;
    wire [15:0] thr_hi, thr_lo;
    wire [31:0] rdata, up_lim, lo_lim;
    always #50 aclk = ~aclk;
    sgc_general_control #(.CAL_TICKS(TICKS)) uut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .lock_detect(lock), .readback_data(rbk),
        .multiplexed_output_pin(pin), .ramp_enable(ramp),
        .output_phase_sync_enable(sync), .device_power_down(pd),
        .cal_high_compare_rate_range(hi_rng),
        .cal_low_compare_rate_range(lo_rng), .calibration_busy(busy),
        .outputs_disabled(od), .ramp_threshold_value(thr_hi),
        .ramp_threshold_value_low(thr_lo), .ramp_upper_limit(up_lim),
        .ramp_lower_limit(lo_lim)
    );
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            test_done();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    // handshakes judged at the negedge before the taking edge, free of races
    task automatic wr(input logic [6:0] i, input logic [15:0] v,
            input logic [1:0] er);
        logic a, w, b;
        awaddr <= {i, 2'b00};
        wdata <= {16'h0000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            a = awvalid && awready;
            w = wvalid && wready;
            b = bvalid;
            rsp = bresp;
            @(posedge aclk);
            if (a) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end while (!b);
        // bready stays up; a back-to-back call raises it in this time step
        chk("bresp", {30'h0, er}, {30'h0, rsp});
    endtask
    task automatic rd(input logic [6:0] i, input logic [1:0] er);
        logic a, r;
        araddr <= {i, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            a = arvalid && arready;
            r = rvalid;
            got = rdata;
            rsp = rresp;
            @(posedge aclk);
            if (a) arvalid <= 1'b0;
        end while (!r);
        chk("rresp", {30'h0, er}, {30'h0, rsp});
    endtask
    // window covers the slowest divider with margin
    task automatic cal(input logic [15:0] mc);
        wr(MC, mc, 2'b00);
        n = 0;
        seen = 1'b0;
        repeat (80) begin
            @(negedge aclk);
            if (busy === 1'b1) n++;
            if (od === 1'b1) seen = 1'b1;
        end
        @(posedge aclk);
    endtask
    task automatic test_done();
        if (errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(MC, 2'b00);
        chk("main_control", 32'h0, got);
        rd(DIV, 2'b00);
        chk("cal_clock_setup", 32'h3, got);
        rd(FRC, 2'b00);
        chk("output_force_control", 32'h0, got);
        for (int c = 0; c < 4; c++) begin
            wr(MC, 16'(c * 128 + (3 - c) * 32), 2'b00);
            chk("rate ranges", 32'(c * 3 + 3), {28'h0, hi_rng, lo_rng});
        end
        wr(MC, 16'h8000, 2'b00);
        chk("ramp sync", 32'h2, {30'h0, ramp, sync});
        wr(MC, 16'h4000, 2'b00);
        chk("ramp sync", 32'h1, {30'h0, ramp, sync});
        rbk <= 1'b1;
        repeat (2) @(posedge aclk);
        chk("pin readback", 32'h1, {31'h0, pin});
        wr(MC, 16'h0004, 2'b00);
        repeat (2) @(posedge aclk);
        chk("pin lock", 32'h0, {31'h0, pin});
        lock <= 1'b1;
        rbk <= 1'b0;
        repeat (2) @(posedge aclk);
        chk("pin lock", 32'h1, {31'h0, pin});
        wr(MC, 16'h0005, 2'b00);
        @(posedge aclk);
        chk("power down", 32'h6, {29'h0, pd, od, pin});
        wr(MC, 16'h0004, 2'b00);
        repeat (2) @(posedge aclk);
        chk("power up", 32'h1, {29'h0, pd, od, pin});
        rd(`SGC_IDX_STATUS, 2'b00);
        chk("status", 32'h2, got);
        // bit 3 stays stored; each pass retriggers by writing bit 3 as 1 again
        for (int c = 0; c < 4; c++) begin
            wr(DIV, 16'(c), 2'b00);
            cal(16'h0008);
            d = 1 << c;
            chk("cal length", 32'h1,
                {31'h0, n > (TICKS - 1) * d && n <= TICKS * d + 2});
        end
        // divide by 8 left in place, the repeatable setting
        for (int c = 0; c < 4; c++) begin
            // c = 1 and c = 2 keep mute and force opposite
            wr(FRC, 16'((c % 2) * 16384), 2'b00);
            cal(16'((c / 2) * 512 + 8));
            chk("mute", 32'((c / 2) * (1 - c % 2)),
                {31'h0, seen});
        end
        wr(DIV, 16'h0001, 2'b00);
        wr(`SGC_IDX_RAMP_THR_HIGH, 16'h1234, 2'b00);
        chk("threshold", 32'h1234, {16'h0, thr_hi});
        wr(MC, 16'h0002, 2'b00);
        wr(`SGC_IDX_RAMP_THR_HIGH, 16'h5555, 2'b00);
        rd(DIV, 2'b00);
        chk("div in reset", 32'h3, got);
        chk("threshold", 32'h0, {16'h0, thr_hi});
        wr(MC, 16'h0000, 2'b00);
        rd(MC, 2'b00);
        chk("main_control", 32'h0, got);
        wr(`SGC_IDX_RAMP_THR_LOW, 16'h1234, 2'b00);
        // upper byte lane only
        wstrb <= 4'h2;
        wr(`SGC_IDX_RAMP_THR_LOW, 16'habcd, 2'b00);
        wstrb <= 4'hf;
        chk("threshold low", 32'hab34, {16'h0, thr_lo});
        wr(`SGC_IDX_RAMP_UPPER_LOW, 16'hbeef, 2'b00);
        chk("upper limit", 32'h0000beef, up_lim);
        wr(`SGC_IDX_RAMP_UPPER_HIGH, 16'hdead, 2'b00);
        wr(`SGC_IDX_RAMP_LOWER_HIGH, 16'h0bad, 2'b00);
        wr(`SGC_IDX_RAMP_LOWER_LOW, 16'hcafe, 2'b00);
        chk("upper limit", 32'hdeadbeef, up_lim);
        chk("lower limit", 32'h0badcafe, lo_lim);
        wr(7'h02, 16'hffff, 2'b10);
        rd(7'h02, 2'b10);
        chk("unmapped", 32'h0, got);
        wr(`SGC_IDX_STATUS, 16'h0000, 2'b10);
        test_done();
    end
endmodule // testbench
bind sgc_general_control sgc_gc_chk u_chk (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .multiplexed_output_pin, .device_power_down,
    .calibration_busy, .outputs_disabled);
